// File: lrc_chan.sv
`timescale 1ns/1ps
// one regulator control register with pin-driven enable and voltage select
module lrc_chan #(
   parameter bit HAS_FULL = 1'b1
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              wr_en,
   input  wire logic [7:0]        wr_data,
   input  wire logic              seq_apply,
   input  wire logic [2:0]        pin_rise,
   input  wire logic [2:0]        pin_fall,
   output logic [7:0]             ctrl_reg,
   output lrc_pkg::lrc_out_t      out_reg
);
   logic [7:0] ctrl_next;
   logic [7:0] fmask;
   logic       e_rise;
   logic       e_fall;
   logic       v_rise;
   logic       v_fall;

   // regulator5 keeps only enable fields plus the voltage choice bit
   assign fmask = HAS_FULL ? 8'hff : 8'h17;

   function automatic logic pick(input logic [1:0] s, input logic [2:0] e);
      unique case (s)
         lrc_pkg::PSEL_SEQ: pick = 1'b0;
         lrc_pkg::PSEL_P1:  pick = e[0];
         lrc_pkg::PSEL_P2:  pick = e[1];
         lrc_pkg::PSEL_P13: pick = e[2];
      endcase
   endfunction

   assign e_rise = pick(ctrl_reg[lrc_pkg::ESEL_HI:lrc_pkg::ESEL_LO],
                        pin_rise);
   assign e_fall = pick(ctrl_reg[lrc_pkg::ESEL_HI:lrc_pkg::ESEL_LO],
                        pin_fall);
   assign v_rise = HAS_FULL &
      pick(ctrl_reg[lrc_pkg::VSEL_HI:lrc_pkg::VSEL_LO], pin_rise);
   assign v_fall = HAS_FULL &
      pick(ctrl_reg[lrc_pkg::VSEL_HI:lrc_pkg::VSEL_LO], pin_fall);

   // pin edge wins over a write landing in the same cycle
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_en) begin
         ctrl_next = wr_data & fmask;
      end
      if (seq_apply && HAS_FULL &&
          ctrl_reg[lrc_pkg::ESEL_HI:lrc_pkg::ESEL_LO] == lrc_pkg::PSEL_SEQ)
      begin
         ctrl_next[lrc_pkg::BIT_ON] = ctrl_reg[lrc_pkg::BIT_SEQ];
      end
      if (e_rise) begin
         ctrl_next[lrc_pkg::BIT_ON] = 1'b1;
      end else if (e_fall) begin
         ctrl_next[lrc_pkg::BIT_ON] = 1'b0;
      end
      if (v_rise) begin
         ctrl_next[lrc_pkg::BIT_VOLT] = 1'b0;
      end else if (v_fall) begin
         ctrl_next[lrc_pkg::BIT_VOLT] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ctrl_reg <= lrc_pkg::REG_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         out_reg <= '0;
      end else begin
         out_reg.on           <= ctrl_next[lrc_pkg::BIT_ON];
         out_reg.volt_choice  <= ctrl_next[lrc_pkg::BIT_VOLT];
         out_reg.pulldown_off <= ctrl_next[lrc_pkg::BIT_PD];
      end
   end
endmodule

// File: lrc_pkg.sv
// package: register map, field layout and carrier types for regulator control
package lrc_pkg;
   localparam logic [7:0] REG5_IDX = 8'h2a;
   localparam logic [7:0] REG6_IDX = 8'h2b;
   localparam logic [7:0] REG7_IDX = 8'h2c;
   localparam int         BIT_SEQ  = 7;
   localparam int         VSEL_HI  = 6;
   localparam int         VSEL_LO  = 5;
   localparam int         BIT_VOLT = 4;
   localparam int         BIT_PD   = 3;
   localparam int         ESEL_HI  = 2;
   localparam int         ESEL_LO  = 1;
   localparam int         BIT_ON   = 0;
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [1:0] PSEL_SEQ = 2'h0;
   localparam logic [1:0] PSEL_P1  = 2'h1;
   localparam logic [1:0] PSEL_P2  = 2'h2;
   localparam logic [1:0] PSEL_P13 = 2'h3;
   localparam int         NREG     = 3;

   typedef struct packed {
      logic       seq_target;
      logic [1:0] volt_pin_sel;
      logic       volt_choice;
      logic       pulldown_off;
      logic [1:0] enable_pin_sel;
      logic       on;
   } lrc_ctrl_t;

   typedef struct packed {
      logic on;
      logic volt_choice;
      logic pulldown_off;
   } lrc_out_t;
endpackage

// File: lrc_top.sv
`timescale 1ns/1ps
// apb register bank for three regulator control registers
module lrc_top (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              seq_apply,
   input  wire logic              general_pin_1,
   input  wire logic              general_pin_2,
   input  wire logic              general_pin_13,
   output lrc_pkg::lrc_out_t      reg5_out,
   output lrc_pkg::lrc_out_t      reg6_out,
   output lrc_pkg::lrc_out_t      reg7_out
);
   logic [2:0]  pin_meta_reg;
   logic [2:0]  pin_sync_reg;
   logic [2:0]  pin_last_reg;
   logic [2:0]  pin_rise;
   logic [2:0]  pin_fall;
   logic [7:0]  ctrl5;
   logic [7:0]  ctrl6;
   logic [7:0]  ctrl7;
   logic        wr_acc;
   logic        hit5;
   logic        hit6;
   logic        hit7;
   logic [31:0] prdata_next;

   // two flops before any logic sees the pins
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
         pin_last_reg <= 3'h0;
      end else begin
         pin_meta_reg <= {general_pin_13, general_pin_2, general_pin_1};
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end
   assign pin_rise = pin_sync_reg & ~pin_last_reg;
   assign pin_fall = ~pin_sync_reg & pin_last_reg;

   // single-cycle access phase; byte address is the word index times four
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign hit5 = paddr == {2'h0, lrc_pkg::REG5_IDX, 2'h0};
   assign hit6 = paddr == {2'h0, lrc_pkg::REG6_IDX, 2'h0};
   assign hit7 = paddr == {2'h0, lrc_pkg::REG7_IDX, 2'h0};
   assign wr_acc = psel & penable & pwrite & pstrb[0];

   lrc_chan #(.HAS_FULL(1'b0)) u_reg5 (
      .mclk      (mclk),
      .rstn      (rstn),
      .wr_en     (wr_acc & hit5),
      .wr_data   (pwdata[7:0]),
      .seq_apply (seq_apply),
      .pin_rise  (pin_rise),
      .pin_fall  (pin_fall),
      .ctrl_reg  (ctrl5),
      .out_reg   (reg5_out)
   );

   lrc_chan #(.HAS_FULL(1'b1)) u_reg6 (
      .mclk      (mclk),
      .rstn      (rstn),
      .wr_en     (wr_acc & hit6),
      .wr_data   (pwdata[7:0]),
      .seq_apply (seq_apply),
      .pin_rise  (pin_rise),
      .pin_fall  (pin_fall),
      .ctrl_reg  (ctrl6),
      .out_reg   (reg6_out)
   );

   lrc_chan #(.HAS_FULL(1'b1)) u_reg7 (
      .mclk      (mclk),
      .rstn      (rstn),
      .wr_en     (wr_acc & hit7),
      .wr_data   (pwdata[7:0]),
      .seq_apply (seq_apply),
      .pin_rise  (pin_rise),
      .pin_fall  (pin_fall),
      .ctrl_reg  (ctrl7),
      .out_reg   (reg7_out)
   );

   always_comb begin
      prdata_next = 32'h0;
      if (hit5) begin
         prdata_next = {24'h0, ctrl5};
      end else if (hit6) begin
         prdata_next = {24'h0, ctrl6};
      end else if (hit7) begin
         prdata_next = {24'h0, ctrl7};
      end
   end

   // read data registered in setup so it is valid in the access phase
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= prdata_next;
      end
   end

   reg6_on_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctrl6[2:1] == 2'h1 && pin_rise[0] && !pin_fall[0])
      |=> ctrl6[0]) else $error("reg6 pin rise did not enable");
   reg7_off_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctrl7[2:1] == 2'h3 && pin_fall[2])
      |=> !ctrl7[0]) else $error("reg7 pin fall did not disable");
   reg6_volt_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctrl6[6:5] == 2'h2 && pin_fall[1])
      |=> ctrl6[4]) else $error("reg6 fall did not pick level b");
   reg7_volt_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctrl7[6:5] == 2'h1 && pin_rise[0])
      |=> !ctrl7[4]) else $error("reg7 rise did not pick level a");
   reg5_on_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctrl5[2:1] == 2'h2 && pin_fall[1])
      |=> !ctrl5[0]) else $error("reg5 fall did not disable");
   reg6_write_a: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_acc && hit6 && ctrl6[2:1] == 2'h0 && ctrl6[6:5] == 2'h0
       && !seq_apply)
      |=> ctrl6 == $past(pwdata[7:0])) else $error("reg6 write lost");
   reg6_out_a: assert property (@(posedge mclk) disable iff (!rstn)
      reg6_out.on == ctrl6[0] && reg6_out.pulldown_off == ctrl6[3]
      && reg6_out.volt_choice == ctrl6[4])
      else $error("reg6 outputs differ from register");
   reg7_out_a: assert property (@(posedge mclk) disable iff (!rstn)
      reg7_out.volt_choice == ctrl7[4] && reg7_out.on == ctrl7[0]
      && reg7_out.pulldown_off == ctrl7[3])
      else $error("reg7 outputs differ from register");
   reg5_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
      (ctrl5 & 8'he8) == 8'h0) else $error("reg5 absent bits set");
   seq6_apply_a: assert property (@(posedge mclk) disable iff (!rstn)
      (seq_apply && !wr_acc && ctrl6[2:1] == 2'h0)
      |=> ctrl6[0] == $past(ctrl6[7])) else $error("reg6 seq target");
   seq7_apply_a: assert property (@(posedge mclk) disable iff (!rstn)
      (seq_apply && ctrl7[2:1] == 2'h0)
      |=> ctrl7[0] == $past(ctrl7[7])) else $error("reg7 seq target");
   reg7_write_a: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_acc && hit7 && ctrl7[2:1] == 2'h0 && ctrl7[6:5] == 2'h0
       && !seq_apply)
      |=> ctrl7 == $past(pwdata[7:0])) else $error("reg7 write lost");
   reg5_write_a: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_acc && hit5 && ctrl5[2:1] == 2'h0)
      |=> ctrl5 == ($past(pwdata[7:0]) & 8'h17))
      else $error("reg5 write lost");
   read6_data_a: assert property (@(posedge mclk) disable iff (!rstn)
      (psel && !penable && !pwrite && hit6)
      |=> prdata == {24'h0, $past(ctrl6)})
      else $error("reg6 read data wrong");
endmodule

// File: lrc_top_tb.sv
`timescale 1ns/1ps
// self-checking bench for the regulator control register bank
module lrc_top_tb;
   logic              mclk      = 1'b0;
   logic              rstn      = 1'b0;
   logic              psel      = 1'b0;
   logic              penable   = 1'b0;
   logic              pwrite    = 1'b0;
   logic [11:0]       paddr     = 12'h000;
   logic [31:0]       pwdata    = 32'h00000000;
   logic [3:0]        pstrb     = 4'h0;
   logic              seq_apply = 1'b0;
   logic [2:0]        pins      = 3'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   lrc_pkg::lrc_out_t reg5_out;
   lrc_pkg::lrc_out_t reg6_out;
   lrc_pkg::lrc_out_t reg7_out;
   logic [7:0]        exp_reg [3];
   logic [11:0]       addr_tab [4];
   int                error_cnt = 0;
   int                tests_run = 0;
   int                cycles    = 0;

   lrc_top dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seq_apply(seq_apply), .general_pin_1(pins[0]),
      .general_pin_2(pins[1]), .general_pin_13(pins[2]),
      .reg5_out(reg5_out), .reg6_out(reg6_out), .reg7_out(reg7_out));

   always #12.5 mclk = ~mclk;

   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // generous ceiling: the whole sequence needs well under 10000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   function automatic logic [2:0] outs(input logic [7:0] r);
      return {r[0], r[4], r[3]};
   endfunction

   // reg5 has no sequencer, voltage pin or pull-down bits
   function automatic logic [7:0] mask(input int i);
      return (i == 0) ? 8'h17 : 8'hff;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask

   // starts just after an edge, ends one idle edge after release
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s, output logic [31:0] rd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      chk({31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr_reg(input int i, input logic [7:0] d,
         input logic [3:0] s);
      logic [31:0] rd;
      logic [31:0] fill;
      fill = $urandom;
      apb(1'b1, addr_tab[i], {fill[31:8], d}, s, rd);
      if (i < 3 && s[0]) exp_reg[i] = d & mask(i);
   endtask

   task automatic check_all;
      logic [31:0] rd;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, addr_tab[i], $urandom, 4'h0, rd);
         chk(rd, (i < 3) ? {24'h0, exp_reg[i]} : 32'h0);
      end
      chk({29'h0, reg5_out}, {29'h0, outs(exp_reg[0])});
      chk({29'h0, reg6_out}, {29'h0, outs(exp_reg[1])});
      chk({29'h0, reg7_out}, {29'h0, outs(exp_reg[2])});
   endtask

   // pin select codes 1..3 map to pins[0..2]
   task automatic pin_edge(input int p);
      logic rise;
      rise = ~pins[p];
      pins[p] <= rise;
      for (int i = 0; i < 3; i++) begin
         if (exp_reg[i][2:1] == 2'(p + 1)) exp_reg[i][0] = rise;
         if (i > 0 && exp_reg[i][6:5] == 2'(p + 1)) exp_reg[i][4] = ~rise;
      end
      repeat (5) @(posedge mclk);
   endtask

   task automatic seq_pulse;
      seq_apply <= 1'b1;
      @(posedge mclk);
      seq_apply <= 1'b0;
      for (int i = 1; i < 3; i++) begin
         if (exp_reg[i][2:1] == 2'h0) exp_reg[i][0] = exp_reg[i][7];
      end
      @(posedge mclk);
   endtask

   initial begin
      logic [31:0] seed;
      addr_tab = '{12'(lrc_pkg::REG5_IDX) << 2, 12'(lrc_pkg::REG6_IDX) << 2,
                   12'(lrc_pkg::REG7_IDX) << 2, 12'hb4};
      for (int i = 0; i < 3; i++) exp_reg[i] = lrc_pkg::REG_RST;
      seed = $urandom(97);
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      check_all();
      for (int p = 0; p < 3; p++) begin
         for (int i = 0; i < 3; i++) begin
            wr_reg(i, {1'b0, 2'(p + 1), 1'b1, 1'b1, 2'(p + 1), 1'b0},
                   4'h1);
         end
         pin_edge(p);
         check_all();
         pin_edge(p);
         check_all();
      end
      // mid-run reset: every register and output returns to its reset value
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 3; i++) exp_reg[i] = lrc_pkg::REG_RST;
      @(posedge mclk);
      check_all();
      for (int k = 0; k < 200; k++) begin
         case ($urandom % 3)
            0: wr_reg(int'($urandom % 4), 8'($urandom), 4'($urandom));
            1: pin_edge($urandom % 3);
            default: seq_pulse();
         endcase
         check_all();
      end
      tally_and_finish();
   end
endmodule
